// ===== dmpm_pin_mux.sv
// display memory pin mux: address, pixel data, strobes and shared pin
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dmpm_pin_mux
  import dmpm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host bus configuration pin, high for pci, low for local bus
  input wire logic host_bus_pci,
  // requests from the memory cycle engine and general data bus
  input wire dmpm_mem_req_t mem_req,
  input wire dmpm_pd_req_t pd_req,
  input wire dmpm_gdb_req_t gdb_req,
  // display memory pins
  output logic [DMPM_ADDR_W-1:0] mem_addr_bus,
  input wire logic [DMPM_PD_W-1:0] pixel_data_bus_in,
  output logic [DMPM_PD_W-1:0] pixel_data_bus_out,
  output logic [DMPM_PD_W-1:0] pixel_data_bus_oe,
  output logic first_row_strobe_n,
  output logic [DMPM_CAS_W-1:0] col_strobe_n,
  output logic write_enable_n,
  output logic first_output_enable_n,
  output logic shared_pin_n,
  // returned data and status toward the core
  output logic [DMPM_PD_W-1:0] pixel_rd_data,
  output logic [DMPM_GDB_W-1:0] gdb_rd_data,
  output logic [DMPM_STRAP_W-1:0] strap_bits,
  output logic mem_limit_2mb
);

  // software registers
  logic [7:0] sequencer_config_a_reg;
  logic [7:0] sequencer_config_d_reg;
  logic [7:0] control_reg_36_reg;
  logic local_peripheral_bus_mode_reg;

  // axi state
  // ready flags are registered so every bus output comes straight from a flop
  logic awready_reg;
  logic wready_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // pin side state
  // pixel and bus-type pins are asynchronous to sys_clk, hence the two-flop stages
  logic [DMPM_PD_W-1:0] pd_sync1_reg;
  logic [DMPM_PD_W-1:0] pd_sync2_reg;
  logic pci_sync1_reg;
  logic pci_sync2_reg;
  logic [DMPM_STRAP_W-1:0] strap_reg;
  logic [DMPM_ADDR_W-1:0] mem_addr_reg;
  logic [DMPM_PD_W-1:0] pd_out_reg;
  logic [DMPM_PD_W-1:0] pd_oe_reg;
  logic row0_n_reg;
  logic [DMPM_CAS_W-1:0] cas_n_reg;
  logic we_n_reg;
  logic oe0_n_reg;
  logic shared_n_reg;
  logic limit_reg;
  dmpm_pin_func_t pin_func_reg;
  dmpm_pin_func_t pin_func_next;

  // handshakes and write decode
  // the write commits only once address and data are both captured;
  // holding off while bvalid is up keeps one write in flight at a time
  wire aw_hs = s_axi_awvalid & awready_reg;
  wire w_hs = s_axi_wvalid & wready_reg;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire b_done = bvalid_reg & s_axi_bready;
  wire ar_hs = s_axi_arvalid & arready_reg;
  wire r_done = rvalid_reg & s_axi_rready;
  wire wr_seq_a = do_write & (awaddr_reg == DMPM_OFS_SEQ_CFG_A) & wstrb_reg[0];
  wire wr_seq_d = do_write & (awaddr_reg == DMPM_OFS_SEQ_CFG_D) & wstrb_reg[0];
  wire wr_control_reg_36 = do_write & (awaddr_reg == DMPM_OFS_CTRL_36) & wstrb_reg[0];
  wire wr_mux = do_write & (awaddr_reg == DMPM_OFS_MUX_CTRL) & wstrb_reg[0];
  wire wr_hit = (awaddr_reg == DMPM_OFS_SEQ_CFG_A) | (awaddr_reg == DMPM_OFS_SEQ_CFG_D) |
                (awaddr_reg == DMPM_OFS_CTRL_36) | (awaddr_reg == DMPM_OFS_MUX_CTRL) |
                (awaddr_reg == DMPM_OFS_STRAPS) | (awaddr_reg == DMPM_OFS_PIN_STAT);

  // read decode; strap and pin status are read only
  // unmapped reads return zero with an error response rather than stale data
  wire rd_hit = (s_axi_araddr == DMPM_OFS_SEQ_CFG_A) | (s_axi_araddr == DMPM_OFS_SEQ_CFG_D) |
                (s_axi_araddr == DMPM_OFS_CTRL_36) | (s_axi_araddr == DMPM_OFS_MUX_CTRL) |
                (s_axi_araddr == DMPM_OFS_STRAPS) | (s_axi_araddr == DMPM_OFS_PIN_STAT);
  wire [31:0] pin_stat_word = {27'h0000000, limit_reg, pci_sync2_reg, 1'b0, pin_func_reg};
  wire [31:0] rd_word =
    (s_axi_araddr == DMPM_OFS_SEQ_CFG_A) ? {24'h000000, sequencer_config_a_reg} :
    (s_axi_araddr == DMPM_OFS_SEQ_CFG_D) ? {24'h000000, sequencer_config_d_reg} :
    (s_axi_araddr == DMPM_OFS_CTRL_36) ? {24'h000000, control_reg_36_reg} :
    (s_axi_araddr == DMPM_OFS_MUX_CTRL) ? {31'h00000000, local_peripheral_bus_mode_reg} :
    (s_axi_araddr == DMPM_OFS_STRAPS) ? {3'h0, strap_reg} :
    (s_axi_araddr == DMPM_OFS_PIN_STAT) ? pin_stat_word : 32'h00000000;

  // shared pin selection; the row strobe wins so two functions never meet
  // the bus type comes from the synchronised pin, so a change of host_bus_pci
  // reaches the shared pin three cycles later; it must not toggle in use
  wire feat_en = sequencer_config_d_reg[DMPM_SEQD_FEAT_EN_BIT];
  wire row1_ok = pci_sync2_reg & sequencer_config_a_reg[DMPM_SEQA_ROW1_EN_BIT];
  wire oe1_blocked = local_peripheral_bus_mode_reg & ~pci_sync2_reg;
  wire oe1_ok = ~control_reg_36_reg[DMPM_CONTROL_REG_36_OE1_OFF_BIT] & ~oe1_blocked;
  wire oe1_level = feat_en ? mem_req.oe1 : mem_req.oe0;

  // priority encoder for the shared pin function; idle parks the pin high
  always_comb
  begin
    if (row1_ok)
      pin_func_next = DMPM_PIN_ROW1;
    else if (oe1_ok)
      pin_func_next = DMPM_PIN_OE1;
    else
      pin_func_next = DMPM_PIN_IDLE;
  end

  // general data bus takes the low 24 pixel pins while gdb_req.active is set
  // only the low lanes can be taken over; the upper 40 stay with the pixel request
  wire [DMPM_PD_W-1:0] gdb_data_wide = {{(DMPM_PD_W-DMPM_GDB_W){1'b0}}, gdb_req.data};
  wire [DMPM_PD_W-1:0] gdb_oe_wide = {{(DMPM_PD_W-DMPM_GDB_W){1'b0}}, gdb_req.oe};
  wire [DMPM_PD_W-1:0] gdb_lane = {{(DMPM_PD_W-DMPM_GDB_W){1'b0}}, {DMPM_GDB_W{gdb_req.active}}};
  wire [DMPM_PD_W-1:0] pd_out_next = (gdb_lane & gdb_data_wide) | (~gdb_lane & pd_req.data);
  wire [DMPM_PD_W-1:0] pd_oe_next = (gdb_lane & gdb_oe_wide) | (~gdb_lane & pd_req.oe);

  // write address and data channels, taken in either order
  // awready and wready return only after the response is taken, which costs
  // one idle cycle between writes but needs no skid storage
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= DMPM_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      else if (!aw_full_reg && !bvalid_reg)
        awready_reg <= 1'b1;
      if (w_hs)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      else if (!w_full_reg && !bvalid_reg)
        wready_reg <= 1'b1;
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? DMPM_RESP_OKAY : DMPM_RESP_SLVERR;
      end
      else if (b_done)
        bvalid_reg <= 1'b0;
    end
  end

  // read channel answers one cycle after the address is taken
  // rdata is captured at the address handshake, so a later register change
  // cannot alter a response that is already waiting
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= DMPM_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? DMPM_RESP_OKAY : DMPM_RESP_SLVERR;
    end
    else if (r_done)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
    else if (!rvalid_reg)
      arready_reg <= 1'b1;
  end

  // configuration registers; only byte lane 0 holds data
  // the other byte lanes hold no bits and their strobes are ignored
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      sequencer_config_a_reg <= DMPM_SEQ_CFG_A_RST;
      sequencer_config_d_reg <= DMPM_SEQ_CFG_D_RST;
      control_reg_36_reg <= DMPM_CTRL_36_RST;
      local_peripheral_bus_mode_reg <= DMPM_MUX_LPB_RST;
    end
    else
    begin
      if (wr_seq_a)
        sequencer_config_a_reg <= wdata_reg[7:0];
      if (wr_seq_d)
        sequencer_config_d_reg <= wdata_reg[7:0];
      if (wr_control_reg_36)
        control_reg_36_reg <= wdata_reg[7:0];
      if (wr_mux)
        local_peripheral_bus_mode_reg <= wdata_reg[DMPM_MUX_LPB_BIT];
    end
  end

  // two-stage synchronisers for pins from outside the clock domain
  always_ff @(posedge sys_clk)
  begin
    pd_sync1_reg <= pixel_data_bus_in;
    pd_sync2_reg <= pd_sync1_reg;
    pci_sync1_reg <= host_bus_pci;
    pci_sync2_reg <= pci_sync1_reg;
  end

  // straps follow the pins for the whole reset and hold the last value;
  // a short reset shorter than the sync delay may catch stale levels
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      strap_reg <= pd_sync2_reg[DMPM_STRAP_W-1:0];
  end

  // registered memory pins; strobes idle high, pixel bus released in reset
  // the shared pin follows the next function so level and function switch together;
  // a register write that changes the function reaches the pin one cycle later
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      mem_addr_reg <= {DMPM_ADDR_W{1'b0}};
      pd_out_reg <= {DMPM_PD_W{1'b0}};
      pd_oe_reg <= {DMPM_PD_W{1'b0}};
      row0_n_reg <= 1'b1;
      cas_n_reg <= {DMPM_CAS_W{1'b1}};
      we_n_reg <= 1'b1;
      oe0_n_reg <= 1'b1;
      shared_n_reg <= 1'b1;
      pin_func_reg <= DMPM_PIN_IDLE;
      limit_reg <= 1'b1;
    end
    else
    begin
      mem_addr_reg <= mem_req.addr;
      pd_out_reg <= pd_out_next;
      pd_oe_reg <= pd_oe_next;
      row0_n_reg <= ~mem_req.row0;
      cas_n_reg <= ~mem_req.cas;
      we_n_reg <= ~mem_req.we;
      oe0_n_reg <= ~mem_req.oe0;
      pin_func_reg <= pin_func_next;
      limit_reg <= ~row1_ok;
      case (pin_func_next)
        DMPM_PIN_ROW1: shared_n_reg <= ~mem_req.row1;
        DMPM_PIN_OE1: shared_n_reg <= ~oe1_level;
        default: shared_n_reg <= 1'b1;
      endcase
    end
  end

  // outputs straight from flops
  // status and read data mirror registered state, never raw pins
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign mem_addr_bus = mem_addr_reg;
  assign pixel_data_bus_out = pd_out_reg;
  assign pixel_data_bus_oe = pd_oe_reg;
  assign first_row_strobe_n = row0_n_reg;
  assign col_strobe_n = cas_n_reg;
  assign write_enable_n = we_n_reg;
  assign first_output_enable_n = oe0_n_reg;
  assign shared_pin_n = shared_n_reg;
  assign pixel_rd_data = pd_sync2_reg;
  assign gdb_rd_data = pd_sync2_reg[DMPM_GDB_W-1:0];
  assign strap_bits = strap_reg;
  assign mem_limit_2mb = limit_reg;

endmodule : dmpm_pin_mux
`default_nettype wire

// ===== dmpm_pkg.sv
// shared constants and types of the display memory pin mux
package dmpm_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [7:0] DMPM_OFS_SEQ_CFG_A = 8'h00;
  localparam logic [7:0] DMPM_OFS_SEQ_CFG_D = 8'h04;
  localparam logic [7:0] DMPM_OFS_CTRL_36 = 8'h08;
  localparam logic [7:0] DMPM_OFS_MUX_CTRL = 8'h0c;
  localparam logic [7:0] DMPM_OFS_STRAPS = 8'h10;
  localparam logic [7:0] DMPM_OFS_PIN_STAT = 8'h14;

  // field positions
  localparam int DMPM_SEQA_ROW1_EN_BIT = 6;
  localparam int DMPM_SEQD_FEAT_EN_BIT = 0;
  localparam int DMPM_CONTROL_REG_36_OE1_OFF_BIT = 2;
  localparam int DMPM_MUX_LPB_BIT = 0;

  // reset values
  localparam logic [7:0] DMPM_SEQ_CFG_A_RST = 8'h00;
  localparam logic [7:0] DMPM_SEQ_CFG_D_RST = 8'h00;
  localparam logic [7:0] DMPM_CTRL_36_RST = 8'h00;
  localparam logic DMPM_MUX_LPB_RST = 1'b0;

  // bus widths
  localparam int DMPM_ADDR_W = 9;
  localparam int DMPM_PD_W = 64;
  localparam int DMPM_STRAP_W = 29;
  localparam int DMPM_GDB_W = 24;
  localparam int DMPM_CAS_W = 8;

  // axi response codes
  localparam logic [1:0] DMPM_RESP_OKAY = 2'b00;
  localparam logic [1:0] DMPM_RESP_SLVERR = 2'b10;

  // function on the shared strobe pin
  typedef enum logic [1:0] {
    DMPM_PIN_IDLE = 2'b00,
    DMPM_PIN_OE1 = 2'b01,
    DMPM_PIN_ROW1 = 2'b11
  } dmpm_pin_func_t;

  // memory control request from the cycle engine, active high
  typedef struct packed {
    logic [DMPM_ADDR_W-1:0] addr;
    logic row0;
    logic row1;
    logic [DMPM_CAS_W-1:0] cas;
    logic we;
    logic oe0;
    logic oe1;
  } dmpm_mem_req_t;

  // pixel data request from the cycle engine and general data bus
  typedef struct packed {
    logic [DMPM_PD_W-1:0] data;
    logic [DMPM_PD_W-1:0] oe;
  } dmpm_pd_req_t;

  typedef struct packed {
    logic [DMPM_GDB_W-1:0] data;
    logic [DMPM_GDB_W-1:0] oe;
    logic active;
  } dmpm_gdb_req_t;

endpackage : dmpm_pkg

// ===== dmpm_pin_mux_chk.sv
// port checker for the display memory pin mux
`timescale 1ns/1ps
`default_nettype none
module dmpm_pin_mux_chk
  import dmpm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic host_bus_pci,
  input wire dmpm_mem_req_t mem_req,
  input wire dmpm_pd_req_t pd_req,
  input wire dmpm_gdb_req_t gdb_req,
  input wire logic [DMPM_ADDR_W-1:0] mem_addr_bus,
  input wire logic [DMPM_PD_W-1:0] pixel_data_bus_in,
  input wire logic [DMPM_PD_W-1:0] pixel_data_bus_out,
  input wire logic [DMPM_PD_W-1:0] pixel_data_bus_oe,
  input wire logic first_row_strobe_n,
  input wire logic [DMPM_CAS_W-1:0] col_strobe_n,
  input wire logic write_enable_n,
  input wire logic first_output_enable_n,
  input wire logic shared_pin_n,
  input wire logic [DMPM_PD_W-1:0] pixel_rd_data,
  input wire logic [DMPM_STRAP_W-1:0] strap_bits,
  input wire logic mem_limit_2mb
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // marks that one edge has passed, so $past has a real sample behind it
  logic clk_seen_reg = 1'b0;
  always_ff @(posedge sys_clk)
    clk_seen_reg <= 1'b1;
  // expected pixel drive: the general bus takes the low lines when active
  wire logic [DMPM_PD_W-1:0] exp_oe = gdb_req.active ? {pd_req.oe[63:24], gdb_req.oe} : pd_req.oe;
  wire logic [DMPM_PD_W-1:0] exp_out = gdb_req.active ? {pd_req.data[63:24], gdb_req.data} : pd_req.data;
  addr_follow_a: assert property ($past(rst_b) |-> mem_addr_bus == $past(mem_req.addr))
    else $error("address bus does not follow request");
  strobe_low_a: assert property ($past(rst_b) |-> col_strobe_n == ~$past(mem_req.cas)
    && write_enable_n == !$past(mem_req.we) && first_row_strobe_n == !$past(mem_req.row0)
    && first_output_enable_n == !$past(mem_req.oe0)) else $error("strobe level wrong");
  reset_idle_a: assert property (disable iff (1'b0) clk_seen_reg && !$past(rst_b) |->
    pixel_data_bus_oe == '0 && col_strobe_n == '1 && first_row_strobe_n && shared_pin_n && mem_limit_2mb)
    else $error("reset state wrong");
  strap_hold_a: assert property ($past(rst_b) |-> $stable(strap_bits))
    else $error("straps changed after reset");
  read_path_a: assert property ($past(rst_b) && $past(rst_b, 2) |->
    pixel_rd_data == $past(pixel_data_bus_in, 2)) else $error("pixel read path wrong");
  pixel_drive_a: assert property ($past(rst_b) |-> pixel_data_bus_oe == $past(exp_oe)
    && pixel_data_bus_out == $past(exp_out)) else $error("pixel drive wrong");
  local_no_row_a: assert property ($past(rst_b) && !$past(host_bus_pci) && !$past(host_bus_pci, 2)
    && !$past(host_bus_pci, 3) && !$past(host_bus_pci, 4) && $past(mem_req.row1) && !$past(mem_req.oe0)
    && !$past(mem_req.oe1) |-> shared_pin_n && mem_limit_2mb) else $error("row strobe on local bus");
  bresp_hold_a: assert property (s_axi_bvalid |=> ($past(s_axi_bready) ? !s_axi_bvalid
    : s_axi_bvalid && $stable(s_axi_bresp))) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid |=> ($past(s_axi_rready) ? !s_axi_rvalid
    : s_axi_rvalid && $stable(s_axi_rdata))) else $error("read data dropped");
endmodule : dmpm_pin_mux_chk
bind dmpm_pin_mux dmpm_pin_mux_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .host_bus_pci(host_bus_pci), .mem_req(mem_req),
  .pd_req(pd_req), .gdb_req(gdb_req), .mem_addr_bus(mem_addr_bus), .pixel_data_bus_in(pixel_data_bus_in),
  .pixel_data_bus_out(pixel_data_bus_out), .pixel_data_bus_oe(pixel_data_bus_oe),
  .first_row_strobe_n(first_row_strobe_n), .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
  .first_output_enable_n(first_output_enable_n), .shared_pin_n(shared_pin_n), .pixel_rd_data(pixel_rd_data),
  .strap_bits(strap_bits), .mem_limit_2mb(mem_limit_2mb));
`default_nettype wire

// ===== dmpm_board_model.sv
// board and display memory side of the pixel bus
`timescale 1ns/1ps
`default_nettype none
module dmpm_board_model
  import dmpm_pkg::*;
#(
  parameter logic [DMPM_STRAP_W-1:0] STRAP = 29'h0a5c3e1
)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [DMPM_PD_W-1:0] pixel_data_bus_out,
  input wire logic [DMPM_PD_W-1:0] pixel_data_bus_oe,
  output logic [DMPM_PD_W-1:0] pixel_data_bus_in
);
  logic [DMPM_PD_W-1:0] float_reg;
  // undriven lines wander every cycle so a stale value never looks right
  always_ff @(posedge sys_clk)
    float_reg <= (float_reg === '1) ? '0 : '1;
  // straps are held by resistors only while reset is low
  wire logic [DMPM_PD_W-1:0] idle = rst_b ? float_reg : {float_reg[63:29], STRAP};
  assign pixel_data_bus_in = (pixel_data_bus_oe & pixel_data_bus_out) | (~pixel_data_bus_oe & idle);
endmodule : dmpm_board_model
`default_nettype wire

// ===== tb.sv
// self-checking bench for the display memory pin mux
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dmpm_pkg::*;
  localparam logic [28:0] STRAP = 29'h0a5c3e1;
  logic sys_clk = 1'b0, rst_b = 1'b0, host_bus_pci = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  dmpm_mem_req_t mem_req = '0, m;
  dmpm_pd_req_t pd_req = '0;
  dmpm_gdb_req_t gdb_req = '0;
  wire logic [63:0] pd_in, pd_out, pd_oe, pd_rd;
  wire logic [8:0] ma;
  wire logic [7:0] cas_n;
  wire logic [28:0] straps;
  wire logic [23:0] gdb_rd;
  wire logic ras0_n, we_n, oe0_n, shr_n, lim;
  int miscompares = 0, samples_checked = 0;
  logic rf, of;
  dmpm_pin_mux DUT (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .host_bus_pci(host_bus_pci), .mem_req(mem_req), .pd_req(pd_req), .gdb_req(gdb_req), .mem_addr_bus(ma),
    .pixel_data_bus_in(pd_in), .pixel_data_bus_out(pd_out), .pixel_data_bus_oe(pd_oe),
    .first_row_strobe_n(ras0_n), .col_strobe_n(cas_n), .write_enable_n(we_n), .first_output_enable_n(oe0_n),
    .shared_pin_n(shr_n), .pixel_rd_data(pd_rd), .gdb_rd_data(gdb_rd), .strap_bits(straps), .mem_limit_2mb(lim));
  dmpm_board_model #(.STRAP(STRAP)) u_board (.sys_clk(sys_clk), .rst_b(rst_b), .pixel_data_bus_out(pd_out),
    .pixel_data_bus_oe(pd_oe), .pixel_data_bus_in(pd_in));
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // waits at the falling edge so the handshake seen is the one sampled next
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    logic ta, tw, got_b;
    n = 0;
    got_b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got_b && n < 50)
    begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      got_b = s_axi_bvalid;
      if (got_b) chk(s_axi_bresp, er);
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!got_b)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ta, tr;
    n = 0;
    tr = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr && n < 50)
    begin
      @(negedge sys_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk({s_axi_rresp, s_axi_rdata}, {er, ed});
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!tr)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask : rd
  task automatic drive(input dmpm_mem_req_t r, input int w);
    mem_req <= r;
    repeat (w) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask : drive
  initial
  begin
    repeat (4) @(negedge sys_clk);
    chk(pd_oe, 64'h0);
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(straps, STRAP);
    rd(DMPM_OFS_STRAPS, {3'h0, STRAP}, DMPM_RESP_OKAY);
    rd(DMPM_OFS_SEQ_CFG_A, 32'h0, DMPM_RESP_OKAY);
    rd(DMPM_OFS_SEQ_CFG_D, 32'h0, DMPM_RESP_OKAY);
    rd(DMPM_OFS_CTRL_36, 32'h0, DMPM_RESP_OKAY);
    rd(8'h18, 32'h0, DMPM_RESP_SLVERR);
    wr(8'h18, 32'hff, 4'hf, DMPM_RESP_SLVERR);
    wr(DMPM_OFS_STRAPS, 32'h0, 4'hf, DMPM_RESP_OKAY);
    rd(DMPM_OFS_STRAPS, {3'h0, STRAP}, DMPM_RESP_OKAY);
    wr(DMPM_OFS_SEQ_CFG_A, 32'hff, 4'he, DMPM_RESP_OKAY);
    rd(DMPM_OFS_SEQ_CFG_A, 32'h0, DMPM_RESP_OKAY);
    $display("test registers done");
    m = '0;
    m.addr = 9'h1a5;
    m.cas = 8'h01;
    m.we = 1'b1;
    drive(m, 2);
    chk({ma, cas_n, we_n, ras0_n, oe0_n}, {9'h1a5, 8'hfe, 1'b0, 1'b1, 1'b1});
    m = '0;
    m.addr = 9'h05a;
    m.cas = 8'h80;
    m.row0 = 1'b1;
    m.oe0 = 1'b1;
    drive(m, 2);
    chk({ma, cas_n, we_n, ras0_n, oe0_n}, {9'h05a, 8'h7f, 1'b1, 1'b0, 1'b0});
    $display("test strobes done");
    // every combination of bus type and the four control bits
    for (int i = 0; i < 32; i++)
    begin
      host_bus_pci <= i[0];
      wr(DMPM_OFS_SEQ_CFG_A, {25'h0, i[1], 6'h0}, 4'h1, DMPM_RESP_OKAY);
      wr(DMPM_OFS_CTRL_36, {29'h0, i[2], 2'h0}, 4'h1, DMPM_RESP_OKAY);
      wr(DMPM_OFS_SEQ_CFG_D, {31'h0, i[3]}, 4'h1, DMPM_RESP_OKAY);
      wr(DMPM_OFS_MUX_CTRL, {31'h0, i[4]}, 4'h1, DMPM_RESP_OKAY);
      rf = i[0] & i[1];
      of = !rf && !i[2] && !(i[4] && !i[0]);
      rd(DMPM_OFS_PIN_STAT, {27'h0, !rf, i[0], 1'b0, rf, rf | of}, DMPM_RESP_OKAY);
      for (int j = 0; j < 3; j++)
      begin
        m = '0;
        m.row1 = (j == 0);
        m.oe0 = (j == 1);
        m.oe1 = (j == 2);
        drive(m, 3);
        chk(shr_n, !((rf && j == 0) || (of && !i[3] && j == 1) || (of && i[3] && j == 2)));
        chk(lim, !rf);
      end
    end
    $display("test shared pin done");
    pd_req <= '{data: 64'hfedc_ba98_7654_3210, oe: '1};
    gdb_req <= '{data: 24'h13579b, oe: 24'h00ff0f, active: 1'b1};
    repeat (2) @(negedge sys_clk);
    chk(pd_oe, 64'hffff_ffff_ff00_ff0f);
    chk(pd_out[63:24], 40'hfedc_ba98_76);
    chk(pd_out[23:0], 24'h13579b);
    @(posedge sys_clk);
    gdb_req <= '0;
    repeat (4) @(negedge sys_clk);
    chk(pd_rd, 64'hfedc_ba98_7654_3210);
    chk(gdb_rd, 24'h543210);
    $display("test pixel bus done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
